//--- logic/copro_handshake_port.sv
`timescale 1ns/1ps
// ************************************************
// core-side end of the pipelined coprocessor port
// ************************************************
module copro_handshake_port (
  input wire logic sys_clk, // 125 MHz system clock, shared with follower
  input wire logic rst_b, // async reset, active low
  input wire logic core_advance, // core pipeline advances this cycle
  input wire logic core_instr_request_n, // core instruction fetch request, low active
  input wire logic [copro_port_pkg::WORD_W-1:0] core_instr_word, // fetched instruction
  input wire logic exec_copro_start, // copro instruction enters Execute (pulse)
  input wire logic exec_cond_pass, // its condition codes passed
  input wire logic exec_is_mem, // it is a memory_transfer_class instruction
  input wire logic [copro_port_pkg::ADDR_W-1:0] exec_addr, // transfer address from core
  input wire logic [copro_port_pkg::WORD_W-1:0] core_store_data, // data for the coprocessor
  input wire logic irq_pending, // interrupt wants the core
  input wire logic prev_data_abort, // preceding instruction took a data abort
  input wire logic [1:0] decode_handshake, // follower Decode answer
  input wire logic [1:0] execute_handshake, // follower Execute answer
  input wire logic [copro_port_pkg::WORD_W-1:0] data_from_copro, // combined read data
  output logic follower_advance_enable, // follower may advance
  output logic fetch_request_n, // registered fetch request, low active
  output logic [copro_port_pkg::WORD_W-1:0] instr_bus_to_follower, // instruction word
  output logic [copro_port_pkg::WORD_W-1:0] data_to_copro, // registered store data
  output logic execute_commit_flag, // copro instruction passed and must run
  output logic late_cancel_flag, // cancel after a data abort
  output logic data_mem_request_n, // data memory request, low active
  output logic [copro_port_pkg::ADDR_W-1:0] data_mem_addr, // transfer address
  output logic undef_trap, // undefined instruction trap (pulse)
  output logic core_busy_wait, // core held in busy-wait
  output logic copro_done, // instruction finished (pulse)
  output logic [copro_port_pkg::WORD_W-1:0] copro_read_data // word taken from coprocessor
);
  import copro_port_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_XFER} port_state_t;

  port_state_t state_reg, state_next;
  logic advance_reg, advance_next;
  logic commit_reg, commit_next;
  logic cancel_reg, cancel_next;
  logic first_exec_reg, first_exec_next;
  logic mem_reg, mem_next;
  logic dreq_n_reg, dreq_n_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic undef_reg, undef_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic [WORD_W-1:0] rdata_reg, rdata_next;
  logic start_take;
  logic [1:0] hs;

  // ************************************************
  // follower-facing copies, all one cycle late
  // ************************************************
  copro_out_stage #(.WIDTH(1), .RESET_VALUE(REQ_N_RESET)) u_fetch_req (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .d(core_instr_request_n),
    .q(fetch_request_n)
  );
  copro_out_stage #(.WIDTH(WORD_W), .RESET_VALUE(WORD_RESET)) u_instr (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .d(core_instr_word),
    .q(instr_bus_to_follower)
  );
  copro_out_stage #(.WIDTH(WORD_W), .RESET_VALUE(WORD_RESET)) u_store (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .d(core_store_data),
    .q(data_to_copro)
  );

  // handshake in use: decode on Execute entry, execute on later cycles
  always_comb
  begin
    start_take = (state_reg == ST_IDLE) && exec_copro_start && exec_cond_pass;
    hs = (state_reg == ST_IDLE) ? decode_handshake : execute_handshake;
  end

  // ************************************************
  // execute sequencer
  // ************************************************
  // a failed-condition instruction never raises commit, so the follower sees it skipped
  always_comb
  begin
    state_next = state_reg;
    advance_next = core_advance;
    commit_next = 1'b0;
    cancel_next = first_exec_reg && prev_data_abort;
    first_exec_next = start_take;
    mem_next = mem_reg;
    dreq_n_next = 1'b1;
    addr_next = addr_reg;
    undef_next = 1'b0;
    busy_next = 1'b0;
    done_next = 1'b0;
    rdata_next = rdata_reg;
    if (start_take || state_reg != ST_IDLE)
    begin
      if (start_take)
      begin
        mem_next = exec_is_mem;
        addr_next = exec_addr;
      end
      unique case (hs)
        HS_ABSENT:
        begin
          undef_next = 1'b1;
          state_next = ST_IDLE;
        end
        HS_WAIT:
        begin
          if (state_reg == ST_BUSY && irq_pending)
          begin
            state_next = ST_IDLE; // abandoned, commit drops
          end
          else
          begin
            state_next = ST_BUSY;
            commit_next = 1'b1;
            busy_next = 1'b1;
          end
        end
        HS_GO:
        begin
          state_next = ST_XFER;
          commit_next = 1'b1;
          dreq_n_next = !(start_take ? exec_is_mem : mem_reg);
        end
        HS_LAST:
        begin
          state_next = ST_IDLE;
          commit_next = 1'b1;
          done_next = 1'b1;
          dreq_n_next = !(start_take ? exec_is_mem : mem_reg);
        end
      endcase
      // each further word of a transfer moves the address on by one word
      if (state_reg == ST_XFER && (hs == HS_GO || hs == HS_LAST))
      begin
        addr_next = addr_reg + ADDR_W'(4);
        rdata_next = data_from_copro;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_IDLE;
      advance_reg <= ENABLE_RESET;
      commit_reg <= 1'b0;
      cancel_reg <= 1'b0;
      first_exec_reg <= 1'b0;
      mem_reg <= 1'b0;
      dreq_n_reg <= REQ_N_RESET;
      addr_reg <= ADDR_RESET;
      undef_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= WORD_RESET;
    end
    else
    begin
      state_reg <= state_next;
      advance_reg <= advance_next;
      commit_reg <= commit_next;
      cancel_reg <= cancel_next;
      first_exec_reg <= first_exec_next;
      mem_reg <= mem_next;
      dreq_n_reg <= dreq_n_next;
      addr_reg <= addr_next;
      undef_reg <= undef_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flops
  assign follower_advance_enable = advance_reg;
  assign execute_commit_flag = commit_reg;
  assign late_cancel_flag = cancel_reg;
  assign data_mem_request_n = dreq_n_reg;
  assign data_mem_addr = addr_reg;
  assign undef_trap = undef_reg;
  assign core_busy_wait = busy_reg;
  assign copro_done = done_reg;
  assign copro_read_data = rdata_reg;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_busy_irq;
    state_reg == ST_BUSY && execute_handshake == HS_WAIT && irq_pending;
  endsequence
  sequence s_wait_then_go;
    state_reg == ST_BUSY && execute_handshake == HS_WAIT && !irq_pending ##1 execute_handshake == HS_GO;
  endsequence

  // the copies only hold from the second edge after a release; the release edge itself is still in reset
  chk_fetch_copy: assert property ($past(rst_b) |-> fetch_request_n == $past(core_instr_request_n))
    else $error("fetch request is not the registered core request");
  chk_instr_copy: assert property ($past(rst_b) |-> instr_bus_to_follower == $past(core_instr_word))
    else $error("instruction bus is not one cycle behind the core");
  chk_advance_copy: assert property ($past(rst_b) |-> follower_advance_enable == $past(core_advance))
    else $error("advance enable does not follow the core");
  chk_absent_trap: assert property (start_take && decode_handshake == HS_ABSENT
      |=> undef_trap && !execute_commit_flag)
    else $error("absent decode answer did not trap");
  chk_busy_absent: assert property (state_reg == ST_BUSY && execute_handshake == HS_ABSENT
      |=> undef_trap ##1 !execute_commit_flag)
    else $error("absent during busy-wait did not trap");
  chk_irq_abandon: assert property (s_busy_irq |=> !execute_commit_flag && !core_busy_wait)
    else $error("interrupt in busy-wait kept commit high");
  chk_wait_go: assert property (s_wait_then_go |=> execute_commit_flag && state_reg == ST_XFER)
    else $error("busy-wait to go lost commit");
  // commit must come from a passed start at the port, or carry on a commit already standing
  chk_commit_cause: assert property (execute_commit_flag
      |-> $past(exec_copro_start && exec_cond_pass) || $past(execute_commit_flag))
    else $error("commit without a passed coprocessor instruction");
  chk_late_cancel: assert property (late_cancel_flag
      |-> $past(start_take, 2) && $past(prev_data_abort))
    else $error("late cancel outside the cycle after first Execute");
  chk_mem_request: assert property (start_take && exec_is_mem && decode_handshake == HS_GO
      |=> !data_mem_request_n && data_mem_addr == $past(exec_addr))
    else $error("memory transfer did not request data memory");
endmodule // copro_handshake_port

//--- logic/copro_out_stage.sv
`timescale 1ns/1ps
// ************************************************
// one registered output stage, so the follower sees clean flop timing
// ************************************************
module copro_out_stage #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [WIDTH-1:0] d, // value from the core
  output logic [WIDTH-1:0] q // registered copy
);
  logic [WIDTH-1:0] q_next;

  // elaboration-time guard: a zero-width stage has nothing to register
  if (WIDTH < 1)
  begin : g_bad_width
    $error("copro_out_stage: WIDTH must be at least 1");
  end

  // plain copy; the one cycle of delay is the whole point
  always_comb
  begin
    q_next = d;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= RESET_VALUE;
    end
    else
    begin
      q <= q_next;
    end
  end
endmodule // copro_out_stage

//--- logic/copro_port_pkg.sv
package copro_port_pkg;
  // ************************************************
  // handshake encoding
  // ************************************************
  localparam logic [1:0] HS_ABSENT = 2'h2;
  localparam logic [1:0] HS_WAIT = 2'h0;
  localparam logic [1:0] HS_GO = 2'h1;
  localparam logic [1:0] HS_LAST = 2'h3;
  // ************************************************
  // widths and reset values
  // ************************************************
  localparam int WORD_W = 32;
  localparam int ADDR_W = 32;
  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
  localparam logic REQ_N_RESET = 1'b1; // requests idle high
  localparam logic ENABLE_RESET = 1'b0;
endpackage

//--- tb/copro_follower_model.sv
`timescale 1ns/1ps
// ********
// coprocessor follower model
// ********
module copro_follower_model (
  input wire logic sys_clk, // clock
  input wire logic rst_b, // async reset
  input wire logic follower_advance_enable, // advance
  input wire logic fetch_request_n, // fetch, low
  input wire logic [copro_port_pkg::WORD_W-1:0] instr_bus_to_follower, // word
  input wire logic execute_commit_flag, // commit
  input wire logic late_cancel_flag, // cancel
  input wire logic copro_start, // job enters execute
  input wire logic load, // arm a job
  input wire logic [3:0] load_waits, // busy cycles
  input wire logic [3:0] load_words, // words
  input wire logic absent, // force absent
  output logic [1:0] decode_handshake, // decode answer
  output logic [1:0] execute_handshake, // execute answer
  output logic [copro_port_pkg::WORD_W-1:0] data_from_copro, // read data
  output logic [copro_port_pkg::WORD_W-1:0] samp_word // sampled word
);
  import copro_port_pkg::*;
  logic [3:0] waits_reg;
  logic [3:0] words_reg;
  logic pend_reg;
  logic commit_reg;
  logic run_reg;
  logic [1:0] hs;
  logic [1:0] dec_hs;
  logic [1:0] ex_hs;
  localparam logic [4:0] OWN_NUM = 5'h00; // number field this follower answers to; value arbitrary
  // one answer, steered below onto the decode or the execute bus; the other bus reads absent
  always_comb
  begin
    if (absent || words_reg == 4'h0) hs = HS_ABSENT;
    else if (waits_reg != 4'h0) hs = HS_WAIT;
    else if (words_reg != 4'h1) hs = HS_GO;
    else hs = HS_LAST;
  end
  // decode answers until the job enters Execute, execute only after, so a swapped bus traps
  assign dec_hs = run_reg ? HS_ABSENT : hs;
  assign ex_hs = run_reg ? hs : HS_ABSENT;
  // a second, absent follower merged in: AND of bit 1, OR of bit 0
  assign decode_handshake = {dec_hs[1] & HS_ABSENT[1], dec_hs[0] | HS_ABSENT[0]};
  assign execute_handshake = {ex_hs[1] & HS_ABSENT[1], ex_hs[0] | HS_ABSENT[0]};
  // zero when idle so several followers can share an or gate; the number-field match is the mux select
  assign data_from_copro = (words_reg != 4'h0 && samp_word[11:7] == OWN_NUM)
    ? {28'ha5a5000, words_reg} : 32'h0;
  // job counters and pipeline; empty after reset
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      waits_reg <= 4'h0;
      words_reg <= 4'h0;
      pend_reg <= 1'b0;
      commit_reg <= 1'b0;
      run_reg <= 1'b0;
      samp_word <= 32'h0;
    end
    else
    begin
      commit_reg <= execute_commit_flag;
      // the job is in Execute once the core starts it; a new load clears that
      if (load) run_reg <= 1'b0;
      else if (copro_start) run_reg <= 1'b1;
      if (follower_advance_enable)
      begin
        pend_reg <= !fetch_request_n;
        if (pend_reg) samp_word <= instr_bus_to_follower;
      end
      if (load) {waits_reg, words_reg} <= {load_waits, load_words};
      else if (late_cancel_flag || (commit_reg && !execute_commit_flag)) words_reg <= 4'h0;
      else if (copro_start || execute_commit_flag)
      begin
        if (waits_reg != 4'h0) waits_reg <= waits_reg - 4'h1;
        else if (words_reg != 4'h0) words_reg <= words_reg - 4'h1;
      end
    end
  end
endmodule // copro_follower_model

//--- tb/tb_copro_handshake_port.sv
`timescale 1ns/1ps
// ********
// bench
// ********
module tb_copro_handshake_port;
  import copro_port_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, core_advance = 1'b0, core_instr_request_n = 1'b1;
  logic exec_copro_start = 1'b0, exec_cond_pass = 1'b0, exec_is_mem = 1'b0, irq_pending = 1'b0;
  logic prev_data_abort = 1'b0, load = 1'b0, absent = 1'b0, copro_start;
  logic [3:0] load_waits = 4'h0, load_words = 4'h0;
  logic [31:0] core_instr_word = 32'h0, exec_addr = 32'h0, core_store_data = 32'h0;
  logic [1:0] decode_handshake, execute_handshake;
  logic [31:0] data_from_copro, samp_word, instr_bus_to_follower, data_to_copro, data_mem_addr, copro_read_data;
  logic follower_advance_enable, fetch_request_n, execute_commit_flag, late_cancel_flag;
  logic data_mem_request_n, undef_trap, core_busy_wait, copro_done;
  int n_errors = 0, num_checks = 0;
  // rows: advance, request, word, store data; outputs copy them one cycle on
  logic [65:0] rows [4] = '{{2'b10, 32'h1234_5678, 32'hdead_beef}, {2'b01, 32'h0, 32'hffff_ffff},
    {2'b11, 32'hffff_ffff, 32'h0}, {2'b00, 32'h8000_0001, 32'h1}};
  always #4 sys_clk = ~sys_clk;
  assign copro_start = exec_copro_start & exec_cond_pass;
  copro_handshake_port i_dut (.*);
  copro_follower_model i_model (.*);
  task automatic chk(input logic [65:0] got, input logic [65:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // next edge; one-shot inputs drop there, outputs are read once settled
  task nxt;
    @(posedge sys_clk);
    {irq_pending, prev_data_abort} <= 2'b00;
    #1;
  endtask
  // arm the model, then send one instruction into execute at edge c0
  task automatic launch(input logic [3:0] w, input logic [3:0] n, input logic mem, input logic pass,
    input logic irq, input logic abrt, input logic abs);
    @(posedge sys_clk);
    {load, load_waits, load_words, absent} <= {1'b1, w, n, 1'b0};
    @(posedge sys_clk);
    {load, exec_copro_start, exec_cond_pass, exec_is_mem, exec_addr} <= {1'b0, 1'b1, pass, mem, 32'h1000};
    @(posedge sys_clk);
    {exec_copro_start, irq_pending, prev_data_abort, absent} <= {1'b0, irq, abrt, abs};
    #1;
  endtask
  // stop a hung run
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    give_verdict;
  end
  initial
  begin
    // rst_b starts low with no falling edge, so the flops take reset at the first clock edge
    @(posedge sys_clk);
    #1;
    chk({fetch_request_n, data_mem_request_n, execute_commit_flag, undef_trap, copro_done}, 5'b11000);
    chk(decode_handshake, HS_ABSENT);
    $display("test reset done");
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      {core_advance, core_instr_request_n, core_instr_word, core_store_data} <= rows[i];
      nxt();
      chk({follower_advance_enable, fetch_request_n, instr_bus_to_follower, data_to_copro}, rows[i]);
    end
    $display("test copies done");
    // a fetch, then the word the follower must sample one enabled edge on
    @(posedge sys_clk);
    {core_advance, core_instr_request_n, core_instr_word} <= {2'b10, 32'h0bad_0001};
    @(posedge sys_clk);
    {core_instr_request_n, core_instr_word} <= {1'b1, 32'h0bad_0002};
    repeat (2) nxt();
    chk(samp_word, 32'h0bad_0002);
    $display("test fetch done");
    // two-word memory transfer: go then last
    launch(4'h0, 4'h2, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    chk({execute_commit_flag, data_mem_request_n, data_mem_addr}, {2'b10, 32'h1000});
    nxt();
    chk({execute_commit_flag, data_mem_request_n, data_mem_addr, copro_done, copro_read_data},
      {2'b10, 32'h1004, 1'b1, 32'ha5a5_0001});
    nxt();
    chk({execute_commit_flag, copro_done, data_mem_request_n}, 3'b001);
    $display("test two-word transfer done");
    // two waits, then a two-word transfer: commit stands throughout
    launch(4'h2, 4'h2, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    chk({execute_commit_flag, core_busy_wait, data_mem_request_n}, 3'b111);
    nxt();
    chk({execute_commit_flag, core_busy_wait, data_mem_request_n}, 3'b111);
    nxt();
    chk({execute_commit_flag, core_busy_wait, data_mem_request_n, data_mem_addr}, {3'b100, 32'h1000});
    nxt();
    chk({execute_commit_flag, data_mem_request_n, copro_done, data_mem_addr}, {3'b101, 32'h1004});
    $display("test wait then go done");
    // busy-wait abandoned by an interrupt
    launch(4'h3, 4'h1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    chk({execute_commit_flag, core_busy_wait}, 2'b11);
    nxt();
    chk({execute_commit_flag, core_busy_wait, copro_done, undef_trap}, 4'b0000);
    $display("test interrupt abandon done");
    // busy-wait whose answer turns absent
    launch(4'h3, 4'h1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    chk({core_busy_wait, undef_trap}, 2'b10);
    nxt();
    chk(undef_trap, 1'b1);
    nxt();
    chk(undef_trap, 1'b0);
    $display("test busy absent done");
    // absent on decode traps at once
    launch(4'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    chk({undef_trap, core_busy_wait}, 2'b10);
    $display("test decode absent done");
    // failed condition never commits
    launch(4'h0, 4'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk({execute_commit_flag, undef_trap, copro_done}, 3'b000);
    $display("test failed condition done");
    // late cancel after a data abort
    launch(4'h0, 4'h1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    chk({execute_commit_flag, late_cancel_flag}, 2'b10);
    nxt();
    chk(late_cancel_flag, 1'b1);
    nxt();
    chk(late_cancel_flag, 1'b0);
    $display("test late cancel done");
    // reset in mid-run: outputs drop at once, copies resume one edge after the release edge
    @(posedge sys_clk);
    rst_b <= 1'b0;
    #1;
    chk({follower_advance_enable, fetch_request_n, instr_bus_to_follower, execute_commit_flag, data_mem_request_n},
      {2'b01, 32'h0, 2'b01});
    @(posedge sys_clk);
    rst_b <= 1'b1;
    nxt();
    chk({follower_advance_enable, fetch_request_n, instr_bus_to_follower}, {2'b11, 32'h0bad_0002});
    $display("test mid-run reset done");
    give_verdict;
  end
endmodule // tb_copro_handshake_port
